// File: src/circ_top.sv
// Configuration words, identity words and regulator start-up sequencer
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Debug word unused bits read one, except reserved bit 7
// - Bit five enables the scan port
// - Channel codes pick program pin pairs
// - Option word unused bits read one
// - Bit four picks two-wire pin set
// - Power bit counts only in crystal mode
// - Bit two one disables tamper input
// - Bit one zero moves comparator inputs
// - Fields erased one, programmed only once
// - Identity word: family and part codes
// - Step word: four-bit revision, upper unused
// - Five 24-bit words form 120-bit identifier
// - Identifier words read-only, consecutive even addresses
// - Nothing user-accessible alters the identifier
// - Hold execution about ten microseconds
// - Delay after every power-down, sleep included
// - Delay length from sleep bit, window
// - Sleep bit zero: standby, wait on wake
// - Crystal select bit qualifies power bit
module circ_top #(
  parameter logic [7:0] FAMILY_CODE = 8'h5A, // Arbitrary value
  parameter logic [7:0] PART_CODE = 8'hA5, // Arbitrary value
  parameter logic [3:0] STEP_CODE = 4'h1, // Arbitrary value
  parameter logic [119:0] UNIQUE_ID = 120'h0123456789ABCDEF0123456789ABCD, // Arbitrary value
  parameter int REGULATOR_STARTUP_DELAY_CYCLES = circ_pkg::REGULATOR_STARTUP_DELAY_CYC,
  parameter int REGULATOR_STARTUP_DELAY_SHORT_CYCLES = circ_pkg::REGULATOR_STARTUP_DELAY_CYC / 2
) (
  input wire logic CORE_CLK,
  input wire logic RESET,
  input wire logic [23:0] NV_DEBUG_WORD,
  input wire logic [23:0] NV_OPTION_WORD,
  input wire logic NV_SOSC_CRYSTAL,
  input wire logic [1:0] NV_WDT_WINDOW,
  input wire logic REG_ACTIVE_IN_SLEEP,
  input wire logic [circ_pkg::ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [circ_pkg::ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output logic SCAN_PORT_ENABLE,
  output logic PROGRAM_PIN_PAIR_1,
  output logic PROGRAM_PIN_PAIR_2,
  output logic PROGRAM_PIN_PAIR_3,
  output logic TWO_WIRE_ON_PIN9_8,
  output logic ALT_TWO_WIRE_ON_PIN5_6,
  output logic SOSC_HIGH_POWER,
  output logic TAMPER_INPUT_LOW_ENABLE,
  output logic COMPARATOR_C_ON_PIN9,
  output logic EXEC_ENABLE,
  output logic REGULATOR_STANDBY
);
  localparam int ADDR_W = circ_pkg::ADDR_W;

  // Byte address of a printed index
  function automatic logic [ADDR_W-1:0] idx_addr(input logic [23:0] idx);
    idx_addr = {idx, 2'b00};
  endfunction

  // Program-once merge: a bit may only go from one to zero
  function automatic logic [23:0] po_merge(input logic [23:0] cur, input logic [23:0] req,
                                           input logic [23:0] ones);
    po_merge = (cur & req) | ones;
  endfunction

  logic [23:0] dbg_q;
  logic [23:0] opt_q;
  logic sosc_xtal_q;
  logic [1:0] wdt_win_q;
  logic cfg_loaded_q;
  logic [31:0] prog_ctrl_q;
  circ_pkg::circ_seq_type seq_q;
  logic [31:0] dly_cnt_q;
  logic sleep_req_q;
  logic wake_req_q;
  circ_pkg::circ_debug_type dbg_route;
  circ_pkg::circ_route_type pin_route;

  // AXI state
  logic aw_have_q;
  logic w_have_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic [ADDR_W-1:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_hit;
  logic wr_fire;
  logic wr_hit;

  assign wr_fire = aw_have_q && w_have_q && !S_AXI_BVALID;
  assign wr_hit = (aw_addr_q[ADDR_W-1:12] == '0) &&
                  (aw_addr_q[11:0] == circ_pkg::PROG_CTRL_ADDR ||
                   aw_addr_q[11:0] == circ_pkg::SEQ_CTRL_ADDR);

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      aw_have_q <= 1'b0;
      aw_addr_q <= '0;
      S_AXI_AWREADY <= 1'b0;
    end else if (wr_fire) begin
      aw_have_q <= 1'b0;
      S_AXI_AWREADY <= 1'b0;
    end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      aw_have_q <= 1'b1;
      aw_addr_q <= S_AXI_AWADDR;
      S_AXI_AWREADY <= 1'b0;
    end else begin
      S_AXI_AWREADY <= !aw_have_q && !S_AXI_BVALID;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      w_have_q <= 1'b0;
      w_data_q <= '0;
      w_strb_q <= '0;
      S_AXI_WREADY <= 1'b0;
    end else if (wr_fire) begin
      w_have_q <= 1'b0;
      S_AXI_WREADY <= 1'b0;
    end else if (S_AXI_WVALID && S_AXI_WREADY) begin
      w_have_q <= 1'b1;
      w_data_q <= S_AXI_WDATA;
      w_strb_q <= S_AXI_WSTRB;
      S_AXI_WREADY <= 1'b0;
    end else begin
      S_AXI_WREADY <= !w_have_q && !S_AXI_BVALID;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= circ_pkg::AXI_OKAY;
    end else if (wr_fire) begin
      S_AXI_BVALID <= 1'b1;
      // Identifier and identity words refuse writes
      S_AXI_BRESP <= wr_hit ? circ_pkg::AXI_OKAY : circ_pkg::AXI_SLVERR;
    end else if (S_AXI_BREADY) begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  // Programming request register; the go bit self-clears
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      prog_ctrl_q <= '0;
    end else if (wr_fire && wr_hit && aw_addr_q[11:0] == circ_pkg::PROG_CTRL_ADDR) begin
      for (int i = 0; i < 4; i++) begin
        if (w_strb_q[i]) begin
          prog_ctrl_q[i*8 +: 8] <= w_data_q[i*8 +: 8];
        end
      end
    end else begin
      prog_ctrl_q[circ_pkg::PROG_GO_BIT] <= 1'b0;
    end
  end

  // Configuration words: loaded at reset, then only one-to-zero programming
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      dbg_q <= circ_pkg::CFG_ERASED;
      opt_q <= circ_pkg::CFG_ERASED;
      sosc_xtal_q <= 1'b1;
      wdt_win_q <= 2'h3;
      cfg_loaded_q <= 1'b0;
    end else if (!cfg_loaded_q) begin
      // Captured in the first cycle after release, held until next reset
      dbg_q <= NV_DEBUG_WORD | circ_pkg::DBG_ONES_MASK;
      opt_q <= NV_OPTION_WORD | circ_pkg::OPT_ONES_MASK;
      sosc_xtal_q <= NV_SOSC_CRYSTAL;
      wdt_win_q <= NV_WDT_WINDOW;
      cfg_loaded_q <= 1'b1;
    end else if (prog_ctrl_q[circ_pkg::PROG_GO_BIT]) begin
      // Ones can never be restored, so a programmed field stays put
      if (prog_ctrl_q[circ_pkg::PROG_SEL_BIT]) begin
        opt_q <= po_merge(opt_q, prog_ctrl_q[23:0], circ_pkg::OPT_ONES_MASK);
      end else begin
        dbg_q <= po_merge(dbg_q, prog_ctrl_q[23:0], circ_pkg::DBG_ONES_MASK);
      end
    end
  end

  // Pin routing decode
  always_comb begin
    dbg_route.scan_enable = dbg_q[circ_pkg::DBG_SCAN_BIT];
    dbg_route.pair1 = dbg_q[circ_pkg::DBG_CH_LSB +: 2] == circ_pkg::CH_PAIR1;
    dbg_route.pair2 = dbg_q[circ_pkg::DBG_CH_LSB +: 2] == circ_pkg::CH_PAIR2;
    dbg_route.pair3 = dbg_q[circ_pkg::DBG_CH_LSB +: 2] == circ_pkg::CH_PAIR3;
    pin_route.twi_on_pin9_8 = opt_q[circ_pkg::OPT_TWI_BIT];
    pin_route.twi_on_pin5_6 = !opt_q[circ_pkg::OPT_TWI_BIT];
    // External clock mode leaves the power bit without effect
    pin_route.sosc_high_power = sosc_xtal_q && opt_q[circ_pkg::OPT_SOSC_HP_BIT];
    pin_route.tamper_enable = !opt_q[circ_pkg::OPT_TMPR_BIT];
    pin_route.cmp_c_on_pin9 = !opt_q[circ_pkg::OPT_CMP_BIT];
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      SCAN_PORT_ENABLE <= 1'b0;
      PROGRAM_PIN_PAIR_1 <= 1'b0;
      PROGRAM_PIN_PAIR_2 <= 1'b0;
      PROGRAM_PIN_PAIR_3 <= 1'b0;
      TWO_WIRE_ON_PIN9_8 <= 1'b0;
      ALT_TWO_WIRE_ON_PIN5_6 <= 1'b0;
      SOSC_HIGH_POWER <= 1'b0;
      TAMPER_INPUT_LOW_ENABLE <= 1'b0;
      COMPARATOR_C_ON_PIN9 <= 1'b0;
    end else begin
      SCAN_PORT_ENABLE <= dbg_route.scan_enable;
      PROGRAM_PIN_PAIR_1 <= dbg_route.pair1;
      PROGRAM_PIN_PAIR_2 <= dbg_route.pair2;
      PROGRAM_PIN_PAIR_3 <= dbg_route.pair3;
      TWO_WIRE_ON_PIN9_8 <= pin_route.twi_on_pin9_8;
      ALT_TWO_WIRE_ON_PIN5_6 <= pin_route.twi_on_pin5_6;
      SOSC_HIGH_POWER <= pin_route.sosc_high_power;
      TAMPER_INPUT_LOW_ENABLE <= pin_route.tamper_enable;
      COMPARATOR_C_ON_PIN9 <= pin_route.cmp_c_on_pin9;
    end
  end

  // Sleep and wake requests, self-clearing
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      sleep_req_q <= 1'b0;
      wake_req_q <= 1'b0;
    end else if (wr_fire && wr_hit && aw_addr_q[11:0] == circ_pkg::SEQ_CTRL_ADDR &&
                 w_strb_q[0]) begin
      sleep_req_q <= w_data_q[circ_pkg::SEQ_SLEEP_BIT];
      wake_req_q <= w_data_q[circ_pkg::SEQ_WAKE_BIT];
    end else begin
      sleep_req_q <= 1'b0;
      wake_req_q <= 1'b0;
    end
  end

  // Regulator start-up sequencer
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      seq_q <= circ_pkg::SEQ_RESET;
      dly_cnt_q <= '0;
      EXEC_ENABLE <= 1'b0;
      REGULATOR_STANDBY <= 1'b0;
    end else begin
      case (seq_q)
        circ_pkg::SEQ_RESET: begin
          if (cfg_loaded_q) begin
            seq_q <= circ_pkg::SEQ_DELAY;
            dly_cnt_q <= 32'(REGULATOR_STARTUP_DELAY_CYCLES - 1);
          end
        end
        circ_pkg::SEQ_DELAY: begin
          if (dly_cnt_q == '0) begin
            seq_q <= circ_pkg::SEQ_RUN;
            EXEC_ENABLE <= 1'b1;
          end else begin
            dly_cnt_q <= dly_cnt_q - 32'd1;
          end
        end
        circ_pkg::SEQ_RUN: begin
          if (sleep_req_q) begin
            seq_q <= circ_pkg::SEQ_SLEEP;
            EXEC_ENABLE <= 1'b0;
            REGULATOR_STANDBY <= !REG_ACTIVE_IN_SLEEP;
          end
        end
        circ_pkg::SEQ_SLEEP: begin
          if (wake_req_q) begin
            seq_q <= circ_pkg::SEQ_DELAY;
            REGULATOR_STANDBY <= 1'b0;
            // Standby, or the narrowest window even without standby, takes the full delay
            dly_cnt_q <= (REGULATOR_STANDBY || wdt_win_q == 2'h0) ?
                         32'(REGULATOR_STARTUP_DELAY_CYCLES - 1) : 32'(REGULATOR_STARTUP_DELAY_SHORT_CYCLES - 1);
          end
        end
        default: begin
          seq_q <= circ_pkg::SEQ_RESET;
        end
      endcase
    end
  end

  // Read path
  assign rd_addr = S_AXI_ARADDR;
  always_comb begin
    rd_hit = 1'b1;
    rd_data = '0;
    if (rd_addr == idx_addr(circ_pkg::UID1_IDX)) begin
      rd_data = {8'h00, UNIQUE_ID[119:96]};
    end else if (rd_addr == idx_addr(circ_pkg::UID2_IDX)) begin
      rd_data = {8'h00, UNIQUE_ID[95:72]};
    end else if (rd_addr == idx_addr(circ_pkg::UID3_IDX)) begin
      rd_data = {8'h00, UNIQUE_ID[71:48]};
    end else if (rd_addr == idx_addr(circ_pkg::UID4_IDX)) begin
      rd_data = {8'h00, UNIQUE_ID[47:24]};
    end else if (rd_addr == idx_addr(circ_pkg::UID5_IDX)) begin
      rd_data = {8'h00, UNIQUE_ID[23:0]};
    end else if (rd_addr == idx_addr(circ_pkg::PART_ID_IDX)) begin
      rd_data = {16'h0000, FAMILY_CODE, PART_CODE};
    end else if (rd_addr == idx_addr(circ_pkg::STEP_IDX)) begin
      rd_data = {28'h0000000, STEP_CODE};
    end else if (rd_addr == {14'h0000, circ_pkg::DBG_CFG_ADDR}) begin
      rd_data = {8'h00, dbg_q};
    end else if (rd_addr == {14'h0000, circ_pkg::OPT_ADDR}) begin
      rd_data = {8'h00, opt_q};
    end else if (rd_addr == {14'h0000, circ_pkg::PROG_CTRL_ADDR}) begin
      rd_data = prog_ctrl_q;
    end else if (rd_addr == {14'h0000, circ_pkg::SEQ_CTRL_ADDR}) begin
      rd_data = '0;
    end else if (rd_addr == {14'h0000, circ_pkg::SEQ_STAT_ADDR}) begin
      rd_data[circ_pkg::SEQ_RUN_BIT] = EXEC_ENABLE;
      rd_data[circ_pkg::SEQ_STBY_BIT] = REGULATOR_STANDBY;
      rd_data[circ_pkg::SEQ_DLY_BIT] = seq_q == circ_pkg::SEQ_DELAY;
    end else if (rd_addr == {14'h0000, circ_pkg::ROUTE_STAT_ADDR}) begin
      rd_data = {23'h000000, dbg_route, pin_route};
    end else begin
      rd_hit = 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= '0;
      S_AXI_RRESP <= circ_pkg::AXI_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA <= rd_data;
      S_AXI_RRESP <= rd_hit ? circ_pkg::AXI_OKAY : circ_pkg::AXI_SLVERR;
    end else if (S_AXI_RVALID) begin
      S_AXI_RVALID <= !S_AXI_RREADY;
    end else begin
      S_AXI_ARREADY <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// File: src/circ_pkg.sv
// Package for the configuration, identity and regulator sequencing block
package circ_pkg;
  // Register indices (printed offsets are not all multiples of four)
  localparam logic [23:0] UID1_IDX = 24'h801600;
  localparam logic [23:0] UID2_IDX = 24'h801602;
  localparam logic [23:0] UID3_IDX = 24'h801604;
  localparam logic [23:0] UID4_IDX = 24'h801606;
  localparam logic [23:0] UID5_IDX = 24'h801608;
  localparam logic [23:0] PART_ID_IDX = 24'hFF0000;
  localparam logic [23:0] STEP_IDX = 24'hFF0002;
  // Own offsets, byte addresses in the low window
  localparam logic [11:0] DBG_CFG_ADDR = 12'h000;
  localparam logic [11:0] OPT_ADDR = 12'h004;
  localparam logic [11:0] PROG_CTRL_ADDR = 12'h008;
  localparam logic [11:0] SEQ_CTRL_ADDR = 12'h00C;
  localparam logic [11:0] SEQ_STAT_ADDR = 12'h010;
  localparam logic [11:0] ROUTE_STAT_ADDR = 12'h014;
  localparam int ADDR_W = 26;
  // Debug word layout
  localparam logic [23:0] DBG_ONES_MASK = 24'hFFFF5C;
  localparam int DBG_RSV_BIT = 7;
  localparam int DBG_SCAN_BIT = 5;
  localparam int DBG_CH_LSB = 0;
  // Option word layout
  localparam logic [23:0] OPT_ONES_MASK = 24'hFFFFE1;
  localparam int OPT_TWI_BIT = 4;
  localparam int OPT_SOSC_HP_BIT = 3;
  localparam int OPT_TMPR_BIT = 2;
  localparam int OPT_CMP_BIT = 1;
  localparam logic [23:0] CFG_ERASED = 24'hFFFFFF;
  // Debug channel codes
  localparam logic [1:0] CH_PAIR1 = 2'h3;
  localparam logic [1:0] CH_PAIR2 = 2'h2;
  localparam logic [1:0] CH_PAIR3 = 2'h1;
  // Program control register fields
  localparam int PROG_SEL_BIT = 24;
  localparam int PROG_GO_BIT = 31;
  // Sequencer control and status fields
  localparam int SEQ_SLEEP_BIT = 0;
  localparam int SEQ_WAKE_BIT = 1;
  localparam int SEQ_RUN_BIT = 0;
  localparam int SEQ_STBY_BIT = 1;
  localparam int SEQ_DLY_BIT = 2;
  // Regulator start-up delay
  localparam int CLK_MHZ = 200;
  localparam int REGULATOR_STARTUP_DELAY_US = 10;
  localparam int REGULATOR_STARTUP_DELAY_CYC = REGULATOR_STARTUP_DELAY_US * CLK_MHZ;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  typedef enum {SEQ_RESET, SEQ_DELAY, SEQ_RUN, SEQ_SLEEP} circ_seq_type;

  typedef struct packed {
    logic scan_enable;
    logic pair1;
    logic pair2;
    logic pair3;
  } circ_debug_type;

  typedef struct packed {
    logic twi_on_pin9_8;
    logic twi_on_pin5_6;
    logic sosc_high_power;
    logic tamper_enable;
    logic cmp_c_on_pin9;
  } circ_route_type;
endpackage

// File: tb/circ_checker.sv
// Port checker for the configuration, identity and sequencer block
`timescale 1ns/1ps
`default_nettype none
module circ_checker (
  input wire logic CORE_CLK,
  input wire logic RESET,
  input wire logic [23:0] NV_DEBUG_WORD,
  input wire logic [23:0] NV_OPTION_WORD,
  input wire logic NV_SOSC_CRYSTAL,
  input wire logic SCAN_PORT_ENABLE,
  input wire logic PROGRAM_PIN_PAIR_1,
  input wire logic PROGRAM_PIN_PAIR_2,
  input wire logic PROGRAM_PIN_PAIR_3,
  input wire logic TWO_WIRE_ON_PIN9_8,
  input wire logic ALT_TWO_WIRE_ON_PIN5_6,
  input wire logic SOSC_HIGH_POWER,
  input wire logic TAMPER_INPUT_LOW_ENABLE,
  input wire logic COMPARATOR_C_ON_PIN9,
  input wire logic EXEC_ENABLE,
  input wire logic REGULATOR_STANDBY
);
  logic [2:0] settle_q;
  logic [23:0] dbg_q;
  logic [23:0] opt_q;
  logic xtal_q;
  logic [11:0] low_q;
  logic settled;
  assign settled = settle_q == 3'h4;
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      settle_q <= 3'h0;
    end else if (!settled) begin
      settle_q <= settle_q + 3'h1;
    end
  end
  // Programming only clears bits, so outputs never exceed this snapshot
  always_ff @(posedge CORE_CLK) begin
    if (!RESET && settle_q == 3'h0) begin
      dbg_q <= NV_DEBUG_WORD;
      opt_q <= NV_OPTION_WORD;
      xtal_q <= NV_SOSC_CRYSTAL;
    end
  end
  always_ff @(posedge CORE_CLK) begin
    if (RESET || EXEC_ENABLE) begin
      low_q <= 12'h000;
    end else if (low_q != 12'hFFF) begin
      low_q <= low_q + 12'h001;
    end
  end
  default clocking @(posedge CORE_CLK);
  endclocking
  default disable iff (RESET);
  pair_onehot_a: assert property ($onehot0({PROGRAM_PIN_PAIR_1, PROGRAM_PIN_PAIR_2,
    PROGRAM_PIN_PAIR_3})) else $error("Several program pin pairs selected");
  twi_pins_a: assert property (settled |-> TWO_WIRE_ON_PIN9_8 != ALT_TWO_WIRE_ON_PIN5_6)
    else $error("Two-wire pin sets not exclusive");
  scan_cap_a: assert property (settled && SCAN_PORT_ENABLE |-> dbg_q[5])
    else $error("Scan port on with enable bit clear");
  power_mode_a: assert property (settled && SOSC_HIGH_POWER
    |-> xtal_q && opt_q[3]) else $error("High power outside crystal mode");
  tamper_map_a: assert property (settled && !TAMPER_INPUT_LOW_ENABLE |-> opt_q[2])
    else $error("Tamper input off with field clear");
  cmp_map_a: assert property (settled && !COMPARATOR_C_ON_PIN9 |-> opt_q[1])
    else $error("Comparator input off pin9 with field clear");
  no_rewrite_a: assert property (settled |-> !$rose(SCAN_PORT_ENABLE)
    && !$rose(TWO_WIRE_ON_PIN9_8)) else $error("Programmed field returned to one");
  exec_start_a: assert property ($fell(RESET) |-> !EXEC_ENABLE [*8] ##[1:40] EXEC_ENABLE)
    else $error("Start-up delay length wrong");
  exec_min_a: assert property ($rose(EXEC_ENABLE) |-> low_q >= 12'h00A)
    else $error("Execution resumed before delay");
  standby_wait_a: assert property (REGULATOR_STANDBY |=> !EXEC_ENABLE [*8])
    else $error("Execution during or just after standby");
endmodule
bind circ_top circ_checker u_circ_checker (.CORE_CLK, .RESET, .NV_DEBUG_WORD, .NV_OPTION_WORD,
  .NV_SOSC_CRYSTAL, .SCAN_PORT_ENABLE, .PROGRAM_PIN_PAIR_1, .PROGRAM_PIN_PAIR_2,
  .PROGRAM_PIN_PAIR_3, .TWO_WIRE_ON_PIN9_8, .ALT_TWO_WIRE_ON_PIN5_6, .SOSC_HIGH_POWER,
  .TAMPER_INPUT_LOW_ENABLE, .COMPARATOR_C_ON_PIN9, .EXEC_ENABLE, .REGULATOR_STANDBY);
`default_nettype wire

// File: tb/circ_tb_top.sv
// Self-checking bench for the configuration, identity and sequencer block
`timescale 1ns/1ps
`default_nettype none
module circ_tb_top;
  localparam logic [7:0] FAM = 8'h3C; // Arbitrary value
  localparam logic [7:0] PRT = 8'hC3; // Arbitrary value
  localparam logic [3:0] STP = 4'h6; // Arbitrary value
  localparam logic [119:0] UID = 120'h13579BDF02468ACE13579BDF02468A; // Arbitrary value
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [23:0] nv_dbg = 24'hFFFFFF;
  logic [23:0] nv_opt = 24'hFFFFFF;
  logic nv_xtal = 1'b1;
  logic [1:0] nv_win = 2'h3;
  logic ras = 1'b1;
  logic [25:0] awaddr = 26'h0;
  logic [25:0] araddr = 26'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready;
  logic wready;
  logic bvalid;
  logic arready;
  logic rvalid;
  logic exec;
  logic [1:0] bresp;
  logic [1:0] rresp;
  logic [31:0] rdata;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  int mismatches = 0;
  int checks = 0;
  integer seed = 34;
  always #2.5 clk = ~clk;
  circ_top #(.FAMILY_CODE(FAM), .PART_CODE(PRT), .STEP_CODE(STP), .UNIQUE_ID(UID),
    .REGULATOR_STARTUP_DELAY_CYCLES(20), .REGULATOR_STARTUP_DELAY_SHORT_CYCLES(10)) dut (
    .CORE_CLK(clk), .RESET(rst), .NV_DEBUG_WORD(nv_dbg), .NV_OPTION_WORD(nv_opt),
    .NV_SOSC_CRYSTAL(nv_xtal), .NV_WDT_WINDOW(nv_win), .REG_ACTIVE_IN_SLEEP(ras),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .SCAN_PORT_ENABLE(), .PROGRAM_PIN_PAIR_1(), .PROGRAM_PIN_PAIR_2(), .PROGRAM_PIN_PAIR_3(),
    .TWO_WIRE_ON_PIN9_8(), .ALT_TWO_WIRE_ON_PIN5_6(), .SOSC_HIGH_POWER(),
    .TAMPER_INPUT_LOW_ENABLE(), .COMPARATOR_C_ON_PIN9(), .EXEC_ENABLE(exec),
    .REGULATOR_STANDBY());
  task automatic end_sim();
    if (mismatches == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic cmp(input logic [33:0] e, input logic [33:0] g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %0t expected %h got %h", $time, e, g);
    end
  endtask
  always @(posedge clk) begin
    if (rvalid && rready) cmp(rq.pop_front(), {rresp, rdata});
    if (bvalid && bready) cmp({bq.pop_front(), 32'h0}, {bresp, 32'h0});
  end
  task automatic wr(input logic [25:0] a, input logic [31:0] d, input logic [1:0] r);
    logic aw_done;
    logic w_done;
    bq.push_back(r);
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge clk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge clk);
      if (awvalid && awready) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (!bvalid);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [25:0] a, input logic [33:0] e);
    rq.push_back(e);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge clk);
    rready <= 1'b0;
  endtask
  function automatic logic [33:0] ok(input logic [31:0] d);
    return {circ_pkg::AXI_OKAY, d};
  endfunction
  function automatic logic [31:0] route(input logic [23:0] d, input logic [23:0] o, input logic x);
    return {23'h0, d[5], d[1:0] == 2'h3, d[1:0] == 2'h2, d[1:0] == 2'h1, o[4], !o[4],
      x & o[3], !o[2], !o[1]};
  endfunction
  task automatic wait_exec();
    for (int i = 0; i < 200 && exec !== 1'b1; i++) @(posedge clk);
  endtask
  task automatic seq(input logic [31:0] req, input logic [31:0] stat);
    wr(26'h00C, req, circ_pkg::AXI_OKAY);
    repeat (2) @(posedge clk);
    rd(26'h010, ok(stat));
  endtask
  initial begin
    #50000;
    mismatches++;
    end_sim();
  end
  initial begin
    logic [31:0] r;
    logic [23:0] d;
    logic [23:0] o;
    int k;
    for (int i = 1; i < 4; i++) begin
      r = $random(seed);
      k = r[9:8] % 3;
      // Bit 7 kept one, channel never 00, only one pin9 function chosen
      d = {r[23:8], 1'b1, r[6:2], 2'(i)};
      o = {r[31:13], k == 0, r[11], k != 1, k != 2, r[12]};
      nv_dbg <= d;
      nv_opt <= o;
      nv_xtal <= r[10];
      nv_win <= 2'(i);
      rst <= 1'b1;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      wait_exec();
      rd(26'h010, ok(32'h1));
      rd(26'h000, ok({8'h0, d | circ_pkg::DBG_ONES_MASK}));
      rd(26'h004, ok({8'h0, o | circ_pkg::OPT_ONES_MASK}));
      nv_dbg <= d ^ 24'h000020;
      nv_xtal <= !r[10];
      repeat (3) @(posedge clk);
      rd(26'h000, ok({8'h0, d | circ_pkg::DBG_ONES_MASK}));
      rd(26'h014, ok(route(d, o, r[10])));
    end
    d = d & 24'hFFFFDF;
    o = o & 24'hFFFFEF;
    wr(26'h008, {8'h80, 24'hFFFFDF}, circ_pkg::AXI_OKAY);
    wr(26'h008, {8'h81, 24'hFFFFEF}, circ_pkg::AXI_OKAY);
    wr(26'h008, {8'h80, 24'hFFFFFF}, circ_pkg::AXI_OKAY);
    // Go byte left out by the strobes, so nothing is programmed
    wstrb <= 4'h7;
    wr(26'h008, {8'h80, 24'h000000}, circ_pkg::AXI_OKAY);
    wstrb <= 4'hF;
    repeat (4) @(posedge clk);
    rd(26'h000, ok({8'h0, d | circ_pkg::DBG_ONES_MASK}));
    rd(26'h004, ok({8'h0, o | circ_pkg::OPT_ONES_MASK}));
    rd(26'h014, ok(route(d, o, r[10])));
    rd(26'h3FC0000, ok({16'h0, FAM, PRT}));
    rd(26'h3FC0008, ok({28'h0, STP}));
    for (int n = 0; n < 5; n++) begin
      wr(26'h2005800 + 26'(8 * n), 32'h0, circ_pkg::AXI_SLVERR);
      rd(26'h2005800 + 26'(8 * n), ok({8'h0, UID[119 - 24 * n -: 24]}));
    end
    wr(26'h3FC0000, 32'hFFFF, circ_pkg::AXI_SLVERR);
    wr(26'h000, 32'h0, circ_pkg::AXI_SLVERR);
    rd(26'h018, {circ_pkg::AXI_SLVERR, 32'h0});
    ras <= 1'b0;
    seq(32'h1, 32'h2);
    seq(32'h2, 32'h4);
    wait_exec();
    rd(26'h010, ok(32'h1));
    ras <= 1'b1;
    seq(32'h1, 32'h0);
    wr(26'h00C, 32'h2, circ_pkg::AXI_OKAY);
    // Short delay is over here, a full one would still be running
    repeat (12) @(posedge clk);
    rd(26'h010, ok(32'h1));
    repeat (4) @(posedge clk);
    end_sim();
  end
endmodule
`default_nettype wire
